// File: mac_pkg.sv
// Package of register map, control fields and widths for the multiply-accumulate unit.
`default_nettype none
package mac_pkg;
	localparam int MAC_OP_W = 16;
	localparam int MAC_ACC_W_DEF = 48;
	localparam int MAC_ADDR_W = 4;
	// Word indices; byte address is four times the index.
	localparam logic [MAC_ADDR_W-1:0] MAC_IDX_CTRL = 4'h0;
	localparam logic [MAC_ADDR_W-1:0] MAC_IDX_OPA = 4'h1;
	localparam logic [MAC_ADDR_W-1:0] MAC_IDX_OPB = 4'h2;
	localparam logic [MAC_ADDR_W-1:0] MAC_IDX_ACC_UP = 4'h3;
	localparam logic [MAC_ADDR_W-1:0] MAC_IDX_ACC_MID = 4'h4;
	localparam logic [MAC_ADDR_W-1:0] MAC_IDX_ACC_LO = 4'h5;
	localparam logic [MAC_ADDR_W-1:0] MAC_IDX_RES_HI = 4'h6;
	localparam logic [MAC_ADDR_W-1:0] MAC_IDX_RES_LO = 4'h7;
	// Control register field positions.
	localparam int MAC_B_SIGN = 0;
	localparam int MAC_B_ACC = 1;
	localparam int MAC_B_NEG = 2;
	localparam int MAC_B_COUNT_SEL = 3;
	localparam int MAC_B_SQUARE = 4;
	localparam int MAC_B_CLEAR = 5;
	localparam int MAC_B_BLOCK = 6;
	localparam int MAC_B_OVF = 7;
	localparam logic [7:0] MAC_CTRL_RST = 8'h00;
	localparam logic [15:0] MAC_WORD_RST = 16'h0000;
	localparam logic [31:0] MAC_RD_ZERO = 32'h0000_0000;
	typedef enum logic [1:0] {MAC_ST_IDLE, MAC_ST_ACK} mac_bus_e;
endpackage : mac_pkg
`default_nettype wire

// File: mac_track.sv
// Operand write tracker that decides when an operation is triggered.
`default_nettype none
module mac_track
	import mac_pkg::*;
(
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic wr_a,
	input wire logic wr_b,
	input wire logic ctrl_wr,
	input wire logic square_enable,
	input wire logic operand_count_sel,
	output logic trigger
);
	logic have_a_q;
	logic have_b_q;
	logic [1:0] hits;

	always_comb begin
		hits = {wr_b, wr_a};
		if (square_enable || operand_count_sel) begin
			trigger = |hits;
		end else begin
			trigger = (wr_a && have_b_q) || (wr_b && have_a_q);
		end
	end

	// Rewriting the pending register replaces it; counter resets on control writes.
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			have_a_q <= 1'b0;
			have_b_q <= 1'b0;
		end else if (ctrl_wr || trigger) begin
			have_a_q <= 1'b0;
			have_b_q <= 1'b0;
		end else begin
			have_a_q <= have_a_q | wr_a;
			have_b_q <= have_b_q | wr_b;
		end
	end
endmodule : mac_track
`default_nettype wire

// File: mac_arith.sv
// Combinational product, accumulate and overflow datapath.
`default_nettype none
module mac_arith
	import mac_pkg::*;
#(
	parameter int ACC_W = MAC_ACC_W_DEF
) (
	input wire logic [MAC_OP_W-1:0] opa,
	input wire logic [MAC_OP_W-1:0] opb,
	input wire logic [ACC_W-1:0] acc,
	input wire logic sign_select,
	input wire logic accumulate_enable,
	input wire logic negate_subtract,
	input wire logic acc_write_block,
	output logic [ACC_W-1:0] acc_new,
	output logic [31:0] view,
	output logic ovf
);
	logic signed [2*MAC_OP_W:0] prod_x;
	logic [ACC_W-1:0] prod;
	logic [ACC_W:0] sum1;
	logic [ACC_W-1:0] low1;
	logic [ACC_W-1:0] sum2;
	logic cin_top;
	logic cout;

	always_comb begin
		prod_x = $signed({sign_select ? 1'b0 : opa[MAC_OP_W-1], opa})
			* $signed({sign_select ? 1'b0 : opb[MAC_OP_W-1], opb});
		prod = ACC_W'(prod_x);
		low1 = {1'b0, acc[ACC_W-2:0]}
			+ {1'b0, (negate_subtract ? ~prod[ACC_W-2:0] : prod[ACC_W-2:0])}
			+ {{(ACC_W-1){1'b0}}, negate_subtract};
		cin_top = low1[ACC_W-1];
		// Subtract is add of the complement; carry-out inverted gives borrow.
		sum1 = {1'b0, acc} + {1'b0, negate_subtract ? ~prod : prod}
			+ {{ACC_W{1'b0}}, negate_subtract};
		cout = sum1[ACC_W];
		sum2 = negate_subtract ? sum1[ACC_W-1:0] - prod : sum1[ACC_W-1:0] + prod;
		if (accumulate_enable) begin
			acc_new = sum1[ACC_W-1:0];
			view = acc_write_block ? sum1[31:0] : sum2[31:0];
			if (sign_select) begin
				ovf = negate_subtract ? ~cout : cout;
			end else begin
				// Carry into the sign bit against the carry out of it.
				ovf = cin_top ^ cout;
			end
		end else begin
			acc_new = negate_subtract ? ACC_W'(-prod) : prod;
			view = acc_new[31:0];
			ovf = negate_subtract && sign_select;
		end
	end
endmodule : mac_arith
`default_nettype wire

// File: mac_unit.sv
// Register-mapped multiply-accumulate unit with an Avalon-MM slave port.
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
// Operation
// - Selected operation completes one cycle after the final operand write.
// - Accumulator width is a 32 to 48 bit parameter; upper word optional.
// - Control writes reset the load counter; operands kept unless clear set.
// - Square mode copies a write into both operands and triggers at once.
// - Count select 0 needs both operands; 1 triggers on either write.
// - Rewriting the pending operand replaces it without starting anything.
// - Clear zeroes operands, accumulator, overflow and counter, then self-clears.
// - Write block set keeps the accumulator; clear lets results update it.
// - Result views update on every operation with the low 32 bits.
// - Sign select 0 is signed with sign extension; 1 is unsigned.
// - Sign select leaves accumulator alone; accumulator is always read/write.
// - Accumulate adds or subtracts; plain multiply stores product, optionally negated.
// - Unsigned multiply-negate sets overflow and gives an invalid result.
// - Unsigned accumulate overflow is carry or borrow out of the MSB.
// - Signed overflow is carry mismatch between top magnitude and sign bits.
// - Plain multiply and signed negate clear the overflow flag.
// - Operand writes accepted at any rate and order; start immediately.
// - Results readable next cycle; accumulator updates on the same edge as the result views.
// - Accumulator needs one wait cycle; back-to-back triggers still accepted.
// - Accumulate with accumulator written: views show accumulator plus or minus twice product.
// - Control layout: overflow bit 7 down to sign select bit 0, reset zero.
// - Overflow clears on reset and clear, and is renewed by every new operation; writing 0 to clear inert.
module mac_unit
	import mac_pkg::*;
#(
	parameter int ACC_W = MAC_ACC_W_DEF
) (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic [MAC_ADDR_W-1:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest
);
	localparam int UP_W = (ACC_W > 32) ? ACC_W - 32 : 1;

	logic [MAC_OP_W-1:0] opa_q;
	logic [MAC_OP_W-1:0] opb_q;
	logic [ACC_W-1:0] acc_q;
	logic [31:0] view_q;
	logic [6:0] ctrl_q;
	logic ovf_q;
	logic [31:0] rdata_q;
	logic wait_q;
	mac_bus_e bus_q;
	logic wr_en;
	logic lo_en;
	logic ctrl_wr;
	logic clr;
	logic wr_a;
	logic wr_b;
	logic trigger;
	logic trig_q;
	logic [MAC_OP_W-1:0] wval;
	logic [ACC_W-1:0] acc_new;
	logic [31:0] view;
	logic ovf;

	function automatic logic hit(input logic [MAC_ADDR_W-1:0] a, input logic [MAC_ADDR_W-1:0] i);
		hit = (a == i);
	endfunction : hit

	////////////////////////////////////////////////////////////////////////////////
	// Bus: every access takes one wait cycle, then completes.
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			bus_q <= MAC_ST_IDLE;
			wait_q <= 1'b1;
		end else begin
			case (bus_q)
				MAC_ST_IDLE: begin
					if (avs_read || avs_write) begin
						bus_q <= MAC_ST_ACK;
						wait_q <= 1'b0;
					end
				end
				MAC_ST_ACK: begin
					bus_q <= MAC_ST_IDLE;
					wait_q <= 1'b1;
				end
				default: begin
					bus_q <= MAC_ST_IDLE;
					wait_q <= 1'b1;
				end
			endcase
		end
	end

	assign avs_waitrequest = wait_q;
	assign wr_en = avs_write && (bus_q == MAC_ST_ACK);
	assign lo_en = avs_byteenable[0] || avs_byteenable[1];
	assign ctrl_wr = wr_en && hit(avs_address, MAC_IDX_CTRL) && avs_byteenable[0];
	assign clr = ctrl_wr && avs_writedata[MAC_B_CLEAR];
	assign wr_a = wr_en && lo_en && hit(avs_address, MAC_IDX_OPA) && !clr;
	assign wr_b = wr_en && lo_en && hit(avs_address, MAC_IDX_OPB) && !clr;
	assign wval = avs_writedata[MAC_OP_W-1:0];

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			rdata_q <= MAC_RD_ZERO;
		end else if (avs_read && bus_q == MAC_ST_IDLE) begin
			case (avs_address)
				MAC_IDX_CTRL: rdata_q <= {24'h00_0000, ovf_q, ctrl_q};
				MAC_IDX_OPA: rdata_q <= {16'h0000, opa_q};
				MAC_IDX_OPB: rdata_q <= {16'h0000, opb_q};
				MAC_IDX_ACC_UP: rdata_q <= (ACC_W > 32) ? 32'(acc_q >> 32) : MAC_RD_ZERO;
				MAC_IDX_ACC_MID: rdata_q <= {16'h0000, acc_q[31:16]};
				MAC_IDX_ACC_LO: rdata_q <= {16'h0000, acc_q[15:0]};
				MAC_IDX_RES_HI: rdata_q <= {16'h0000, view_q[31:16]};
				MAC_IDX_RES_LO: rdata_q <= {16'h0000, view_q[15:0]};
				default: rdata_q <= MAC_RD_ZERO;
			endcase
		end
	end

	assign avs_readdata = rdata_q;

	// Each access is answered once, after exactly one wait cycle, with read data held.
	bus_ack_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		(avs_read || avs_write) && bus_q == MAC_ST_IDLE
		|=> !avs_waitrequest) else $error("request not answered");
	bus_once_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		!avs_waitrequest
		|=> avs_waitrequest) else $error("answer held too long");
	bus_idle_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		!avs_read && !avs_write && avs_waitrequest
		|=> avs_waitrequest) else $error("answer without request");
	rd_hold_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		!avs_waitrequest
		|=> $stable(avs_readdata)) else $error("read data moved");
	wr_ack_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		wr_en
		|-> !avs_waitrequest) else $error("write outside answer");

	////////////////////////////////////////////////////////////////////////////////
	// Control register; the clear bit self-clears and is never stored.
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			ctrl_q <= MAC_CTRL_RST[6:0];
		end else if (ctrl_wr) begin
			ctrl_q <= avs_writedata[6:0] & ~(7'h01 << MAC_B_CLEAR);
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Operand registers.
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			opa_q <= MAC_WORD_RST;
			opb_q <= MAC_WORD_RST;
		end else if (clr) begin
			opa_q <= MAC_WORD_RST;
			opb_q <= MAC_WORD_RST;
		end else if (ctrl_q[MAC_B_SQUARE] && (wr_a || wr_b)) begin
			opa_q <= wval;
			opb_q <= wval;
		end else begin
			if (wr_a) begin
				opa_q <= wval;
			end
			if (wr_b) begin
				opb_q <= wval;
			end
		end
	end

	mac_track u_track (
		.core_clk(core_clk),
		.rst_n(rst_n),
		.wr_a(wr_a),
		.wr_b(wr_b),
		.ctrl_wr(ctrl_wr),
		.square_enable(ctrl_q[MAC_B_SQUARE]),
		.operand_count_sel(ctrl_q[MAC_B_COUNT_SEL]),
		.trigger(trigger)
	);

	// Operation runs the cycle after the triggering write, using the stored operands.
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			trig_q <= 1'b0;
		end else begin
			trig_q <= trigger && !ctrl_wr;
		end
	end

	mac_arith #(
		.ACC_W(ACC_W)
	) u_arith (
		.opa(opa_q),
		.opb(opb_q),
		.acc(acc_q),
		.sign_select(ctrl_q[MAC_B_SIGN]),
		.accumulate_enable(ctrl_q[MAC_B_ACC]),
		.negate_subtract(ctrl_q[MAC_B_NEG]),
		.acc_write_block(ctrl_q[MAC_B_BLOCK]),
		.acc_new(acc_new),
		.view(view),
		.ovf(ovf)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Accumulator, result view and overflow.
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			acc_q <= '0;
		end else if (clr) begin
			acc_q <= '0;
		end else if (trig_q && !ctrl_q[MAC_B_BLOCK]) begin
			acc_q <= acc_new;
		end else if (wr_en && lo_en) begin
			if (hit(avs_address, MAC_IDX_ACC_LO)) begin
				acc_q[15:0] <= wval;
			end
			if (hit(avs_address, MAC_IDX_ACC_MID)) begin
				acc_q[31:16] <= wval;
			end
			if (hit(avs_address, MAC_IDX_ACC_UP) && ACC_W > 32) begin
				acc_q <= ACC_W'({UP_W'(avs_writedata), acc_q[31:0]});
			end
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			view_q <= MAC_RD_ZERO;
		end else if (trig_q) begin
			view_q <= view;
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			ovf_q <= 1'b0;
		end else if (trig_q) begin
			ovf_q <= ovf;
		end else if (clr) begin
			ovf_q <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Operation start and results.
	view_update_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		trig_q
		|=> view_q == $past(view)) else $error("view not updated");
	view_hold_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		!trig_q
		|=> $stable(view_q)) else $error("view changed without operation");
	one_cycle_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		trigger && !ctrl_wr
		|=> trig_q) else $error("op not started");
	trig_src_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		trig_q
		|-> $past(trigger)) else $error("op without trigger");
	single_trig_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		ctrl_q[MAC_B_COUNT_SEL] && (wr_a || wr_b)
		|-> trigger) else $error("single operand did not start");
	no_trig_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		!wr_a && !wr_b
		|-> !trigger) else $error("op without operand write");

	////////////////////////////////////////////////////////////////////////////////
	// Operands and control.
	square_copy_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		ctrl_q[MAC_B_SQUARE] && wr_a
		|=> opa_q == opb_q) else $error("square copy");
	square_val_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		ctrl_q[MAC_B_SQUARE] && (wr_a || wr_b)
		|=> opa_q == $past(wval) && opb_q == $past(wval)) else $error("square value");
	square_trig_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		ctrl_q[MAC_B_SQUARE] && (wr_a || wr_b) && !ctrl_wr
		|-> trigger) else $error("sq trig");
	opa_wr_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		wr_a && !ctrl_q[MAC_B_SQUARE]
		|=> opa_q == $past(wval)) else $error("operand a not replaced");
	op_keep_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		!wr_a && !wr_b && !clr
		|=> $stable(opa_q) && $stable(opb_q)) else $error("operand changed");
	ctrl_keep_ops_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		ctrl_wr && !clr
		|=> $stable(opa_q) && $stable(opb_q)) else $error("control write hit operands");
	ctrl_block_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		ctrl_wr
		|=> ctrl_q[MAC_B_BLOCK] == $past(avs_writedata[MAC_B_BLOCK])) else $error("block bit");
	ovf_ro_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		ctrl_wr && !clr && !trig_q
		|=> ovf_q == $past(ovf_q)) else $error("overflow written");
	rd_ctrl_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		avs_read && bus_q == MAC_ST_IDLE && hit(avs_address, MAC_IDX_CTRL)
		|=> avs_readdata[MAC_B_OVF] == $past(ovf_q)) else $error("overflow read");
	rd_view_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		avs_read && bus_q == MAC_ST_IDLE && hit(avs_address, MAC_IDX_RES_LO)
		|=> avs_readdata[15:0] == $past(view_q[15:0])) else $error("view read");

	////////////////////////////////////////////////////////////////////////////////
	// Accumulator, clear and overflow.
	acc_block_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		trig_q && ctrl_q[MAC_B_BLOCK] && !clr
		|=> $stable(acc_q)) else $error("acc written");
	acc_update_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		trig_q && !ctrl_q[MAC_B_BLOCK] && !clr
		|=> acc_q == $past(acc_new)) else $error("acc not updated");
	acc_hold_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		!trig_q && !clr && !wr_en
		|=> $stable(acc_q)) else $error("acc changed while idle");
	acc_lo_wr_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		wr_en && lo_en && hit(avs_address, MAC_IDX_ACC_LO) && !trig_q
		|=> acc_q[15:0] == $past(wval)) else $error("acc low word write");
	acc_mid_wr_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		wr_en && lo_en && hit(avs_address, MAC_IDX_ACC_MID) && !trig_q
		|=> acc_q[31:16] == $past(wval)) else $error("acc middle word write");
	clear_all_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		clr && !trig_q
		|=> acc_q == '0 && opa_q == '0 && !ovf_q) else $error("clear");
	clr_opb_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		clr
		|=> opb_q == MAC_WORD_RST) else $error("clear missed operand b");
	clr_self_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		!ctrl_q[MAC_B_CLEAR])
		else $error("clear bit stuck");
	ovf_op_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		trig_q
		|=> ovf_q == $past(ovf)) else $error("overflow not renewed");
	neg_unsigned_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		trig_q && !ctrl_q[MAC_B_ACC] && ctrl_q[MAC_B_NEG] && ctrl_q[MAC_B_SIGN]
		|=> ovf_q) else $error("unsigned negate ovf");
	plain_ovf_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		trig_q && !ctrl_q[MAC_B_ACC] && !ctrl_q[MAC_B_NEG]
		|=> !ovf_q) else $error("ovf");
	neg_signed_ovf_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		trig_q && !ctrl_q[MAC_B_ACC] && ctrl_q[MAC_B_NEG] && !ctrl_q[MAC_B_SIGN]
		|=> !ovf_q) else $error("signed negate ovf");
endmodule : mac_unit
`default_nettype wire

// File: mac_unit_tb.sv
// Self-checking random bench for the multiply-accumulate unit over its Avalon-MM port.
`default_nettype none
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin err_count++; \
	$display("ERROR %0t got %h expected %h", $time, (g), (e)); end end
module mac_unit_tb
	import mac_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int AW = 48;
	logic core_clk = 1'b0;
	logic rst_n = 1'b0;
	logic [MAC_ADDR_W-1:0] avs_address = '0;
	logic avs_read = 1'b0;
	logic avs_write = 1'b0;
	logic [31:0] avs_writedata = '0;
	logic [3:0] avs_byteenable = 4'hf;
	logic [31:0] avs_readdata;
	logic avs_waitrequest;
	int err_count = 0;
	int comparisons = 0;
	int cyc = 0;
	logic [31:0] rd;
	logic [15:0] opa_s;
	logic [15:0] opb_s;
	logic [15:0] va;
	logic [15:0] vb;
	logic [15:0] vc;
	logic first;
	logic [47:0] acc_s;
	logic [47:0] exp_acc;
	logic [31:0] view_s;
	logic [31:0] exp_view;
	logic [7:0] ctl;
	logic exp_ovf;
	logic chk_ovf;

	mac_unit #(.ACC_W(AW)) dut (
		.core_clk(core_clk),
		.rst_n(rst_n),
		.avs_address(avs_address),
		.avs_read(avs_read),
		.avs_write(avs_write),
		.avs_writedata(avs_writedata),
		.avs_byteenable(avs_byteenable),
		.avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest)
	);

	always #12.5 core_clk = ~core_clk;

	////////////////////////////////////////////////////////////////////////////////
	task automatic complete_run();
		if (err_count == 0 && comparisons > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : complete_run

	always @(posedge core_clk) begin
		cyc++;
		if (cyc == 20000) begin
			err_count++;
			$display("ERROR %0t run limit reached", $time);
			complete_run();
		end
	end

	// One bus transfer; entered just after a rising edge, returns one idle edge later.
	task automatic bus(input logic wr, input logic [MAC_ADDR_W-1:0] idx, input logic [31:0] wd);
		avs_address <= idx;
		avs_write <= wr;
		avs_read <= !wr;
		avs_writedata <= wd;
		// Only the run limit ends a wait that never gets its answer.
		do begin
			@(posedge core_clk);
		end while (avs_waitrequest !== 1'b0);
		rd = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		@(posedge core_clk);
	endtask : bus

	task automatic wr_op(input logic sel, input logic [15:0] v);
		bus(1'b1, sel ? MAC_IDX_OPB : MAC_IDX_OPA, {16'h0000, v});
		if (sel || ctl[MAC_B_SQUARE]) opb_s = v;
		if (!sel || ctl[MAC_B_SQUARE]) opa_s = v;
	endtask : wr_op

	task automatic chk_idle();
		bus(1'b0, MAC_IDX_RES_LO, 32'h0000_0000);
		`CHK(rd[15:0], view_s[15:0])
	endtask : chk_idle

	// Expected view, accumulator and overflow of one operation on the shadow state.
	function automatic void model(input logic [15:0] a, input logic [15:0] b,
		input logic [7:0] c);
		logic signed [31:0] sp;
		logic [47:0] p;
		logic [47:0] r;
		logic [47:0] r2;
		logic [48:0] s;
		sp = $signed(a) * $signed(b);
		p = c[MAC_B_SIGN] ? {16'h0000, {16'h0000, a} * {16'h0000, b}} : {{16{sp[31]}}, sp};
		chk_ovf = 1'b1;
		if (!c[MAC_B_ACC]) begin
			r = c[MAC_B_NEG] ? -p : p;
			exp_view = r[31:0];
			exp_ovf = 1'b0;
		end else begin
			r = c[MAC_B_NEG] ? acc_s - p : acc_s + p;
			r2 = c[MAC_B_NEG] ? acc_s - (p << 1) : acc_s + (p << 1);
			exp_view = c[MAC_B_BLOCK] ? r[31:0] : r2[31:0];
			s = c[MAC_B_NEG] ? {1'b0, acc_s} - {1'b0, p} : {1'b0, acc_s} + {1'b0, p};
			exp_ovf = c[MAC_B_SIGN] ? s[48] : (acc_s[47] ^ r[47]) & (acc_s[47] ^ p[47] ^ !c[MAC_B_NEG]);
			chk_ovf = !c[MAC_B_BLOCK];
		end
		exp_acc = c[MAC_B_BLOCK] ? acc_s : r;
	endfunction : model

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		void'($urandom(19));
		repeat (5) @(posedge core_clk);
		rst_n <= 1'b1;
		@(posedge core_clk);
		for (int k = 0; k < 16; k++) begin
			bus(1'b0, k[3:0], 32'h0000_0000);
			`CHK(rd, MAC_RD_ZERO)
		end
		bus(1'b1, 4'h9, $urandom());
		bus(1'b1, MAC_IDX_RES_HI, $urandom());
		bus(1'b0, 4'h9, 32'h0000_0000);
		`CHK(rd, MAC_RD_ZERO)
		bus(1'b0, MAC_IDX_RES_HI, 32'h0000_0000);
		`CHK(rd, MAC_RD_ZERO)
		opa_s = MAC_WORD_RST;
		opb_s = MAC_WORD_RST;
		view_s = MAC_RD_ZERO;
		for (int i = 0; i < 80; i++) begin
			ctl = 8'($urandom()) & 8'h5f;
			if (i < 16) ctl = {1'b0, i[3], 3'b000, i[2], i[1], i[0]};
			if (!ctl[MAC_B_ACC] && ctl[MAC_B_NEG]) ctl[MAC_B_SIGN] = 1'b0;
			bus(1'b1, MAC_IDX_CTRL, {24'h00_0000, ctl});
			case ($urandom_range(3))
				0: acc_s = 48'h0000_0000_0000;
				1: acc_s = 48'h7fff_ffff_ffff;
				2: acc_s = 48'hffff_ffff_ffff;
				default: acc_s = 48'({$urandom(), $urandom()});
			endcase
			bus(1'b1, MAC_IDX_ACC_UP, {16'h0000, acc_s[47:32]});
			bus(1'b1, MAC_IDX_ACC_MID, {16'h0000, acc_s[31:16]});
			bus(1'b1, MAC_IDX_ACC_LO, {16'h0000, acc_s[15:0]});
			va = ($urandom_range(3) == 0) ? 16'h8000 : 16'($urandom());
			vb = ($urandom_range(3) == 0) ? 16'hffff : 16'($urandom());
			vc = 16'($urandom());
			first = 1'($urandom());
			if (ctl[MAC_B_SQUARE] || ctl[MAC_B_COUNT_SEL]) begin
				wr_op(first, va);
			end else begin
				wr_op(first, vc);
				chk_idle();
				if ($urandom_range(1) == 1) begin
					bus(1'b1, MAC_IDX_CTRL, {24'h00_0000, ctl});
					wr_op(!first, vb);
					chk_idle();
					wr_op(first, va);
				end else begin
					wr_op(first, va);
					chk_idle();
					wr_op(!first, vb);
				end
			end
			model(opa_s, opb_s, ctl);
			bus(1'b0, MAC_IDX_RES_HI, 32'h0000_0000);
			`CHK(rd[15:0], exp_view[31:16])
			bus(1'b0, MAC_IDX_RES_LO, 32'h0000_0000);
			`CHK(rd[15:0], exp_view[15:0])
			bus(1'b0, MAC_IDX_ACC_UP, 32'h0000_0000);
			`CHK(rd[15:0], exp_acc[47:32])
			bus(1'b0, MAC_IDX_ACC_MID, 32'h0000_0000);
			`CHK(rd[15:0], exp_acc[31:16])
			bus(1'b0, MAC_IDX_ACC_LO, 32'h0000_0000);
			`CHK(rd[15:0], exp_acc[15:0])
			bus(1'b0, MAC_IDX_CTRL, 32'h0000_0000);
			`CHK(rd[6:0], ctl[6:0])
			if (chk_ovf) `CHK(rd[MAC_B_OVF], exp_ovf)
			bus(1'b0, MAC_IDX_OPA, 32'h0000_0000);
			`CHK(rd[15:0], opa_s)
			bus(1'b0, MAC_IDX_OPB, 32'h0000_0000);
			`CHK(rd[15:0], opb_s)
			view_s = exp_view;
			acc_s = exp_acc;
		end
		ctl = 8'h0d;
		bus(1'b1, MAC_IDX_CTRL, {24'h00_0000, ctl});
		wr_op(1'b0, 16'h1234);
		bus(1'b0, MAC_IDX_CTRL, 32'h0000_0000);
		`CHK(rd[7:0], 8'h8d)
		bus(1'b1, MAC_IDX_CTRL, 32'h0000_0020);
		bus(1'b0, MAC_IDX_CTRL, 32'h0000_0000);
		`CHK(rd[7:0], MAC_CTRL_RST)
		for (int k = 1; k < 6; k++) begin
			bus(1'b0, k[3:0], 32'h0000_0000);
			`CHK(rd[15:0], MAC_WORD_RST)
		end
		complete_run();
	end
endmodule : mac_unit_tb
`undef CHK
`default_nettype wire
